// ### dv/ssps_link_model.sv
// two-wire and four-wire master model driving the port's link pins
`default_nettype none
module ssps_link_model (
  input wire logic pclk,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic scl,
  output logic sda,
  output logic ss_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_m;
  // open drain with pull-up: a released line reads high
  assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    ss_n = 1'b1;
  end
  // half of a 160 ns link period; clock stands still between frames
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask
  task automatic start();
    sda_m <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask
  // sda changes one half period after scl falls, never with it
  task automatic stop();
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask
  // eight bits msb first, then a ninth clock with sda released
  task automatic xfer(input logic [7:0] b, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      half();
      scl <= 1'b1;
      half();
      r[i] = sda;
      scl <= 1'b0;
    end
    sda_m <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    ack = sda;
    scl <= 1'b0;
  endtask
  // sck idles low before select, so no early shift edge
  task automatic spi(input logic [7:0] b, output logic [7:0] r);
    scl <= 1'b0;
    half();
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      half();
      // an undriven sdo reads inverted, so a missing enable shows
      r[i] = sdo_oe ? sdo : ~sdo;
      scl <= 1'b1;
      half();
      scl <= 1'b0;
    end
    half();
    ss_n <= 1'b1;
    sda_m <= 1'b1;
  endtask
endmodule // ssps_link_model
`default_nettype wire

// ### dv/sync_serial_port_status_tb.sv
// self-checking bench of the serial port status block
`default_nettype none
module sync_serial_port_status_tb import ssps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, r;
  logic [31:0] pwdata, prdata, rv;
  logic scl, sda, ss_n, sda_o, sda_oe, sdo, sdo_oe, ev, ack;
  int fails, n_checks;
  ssps_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .sda_i(sda), .ss_n_i(ss_n), .sda_o(sda_o), .sda_oe(sda_oe), .sdo(sdo),
    .sdo_oe(sdo_oe), .irq(irq));
  ssps_link_model i_link (.pclk(pclk), .sda_o(sda_o), .sda_oe(sda_oe),
    .sdo(sdo), .sdo_oe(sdo_oe), .scl(scl), .sda(sda), .ss_n(ss_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are taken at the rising edge itself
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel at once
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rv & m, exp);
  endtask
  task automatic ckirq(input logic e);
    repeat (2) @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc("status reset", OFF_STAT, 32'hffffffff, 32'h0);
    apb(1'b1, OFF_STAT, 32'hff);
    rdc("status write", OFF_STAT, 32'hffffffff, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", {31'h0, ev}, 32'h1);
    rdc("ctrl reset", OFF_CTRL, 32'h7, 32'h0);
  endtask
  task automatic t_i2c_write();
    apb(1'b1, OFF_CTRL, 32'h3);
    apb(1'b1, OFF_ADDR, 32'h54);
    apb(1'b1, OFF_MASK, 32'h7);
    i_link.start();
    rdc("start", OFF_STAT, 32'hff, 32'h08);
    i_link.xfer(8'h54, r, ack);
    chk("addr ack", {31'h0, ack}, 32'h0);
    rdc("addr byte", OFF_STAT, 32'hff, 32'h08);
    i_link.xfer(8'hc3, r, ack);
    rdc("data byte", OFF_STAT, 32'hff, 32'h29);
    ckirq(1'b1);
    rdc("rx byte", OFF_BUF, 32'hff, 32'hc3);
    rdc("buffer read", OFF_STAT, 32'h01, 32'h0);
    rdc("events", OFF_IRQ, 32'h7, 32'h3);
    ckirq(1'b0);
    i_link.stop();
    rdc("stop", OFF_STAT, 32'h1c, 32'h10);
    ckirq(1'b1);
    apb(1'b1, OFF_MASK, 32'h0);
    ckirq(1'b0);
    rdc("stop event", OFF_IRQ, 32'h7, 32'h4);
  endtask
  task automatic t_i2c_read();
    apb(1'b1, OFF_BUF, 32'ha5);
    i_link.start();
    i_link.xfer(8'h55, r, ack);
    rdc("read addr", OFF_STAT, 32'hff, 32'h0d);
    i_link.xfer(8'hff, r, ack);
    chk("tx byte", {24'h0, r}, 32'ha5);
    rdc("tx done", OFF_STAT, 32'h01, 32'h0);
    i_link.stop();
    apb(1'b1, OFF_CTRL, 32'h0);
    rdc("disabled", OFF_STAT, 32'h18, 32'h0);
  endtask
  task automatic t_ten_bit();
    apb(1'b1, OFF_CTRL, 32'h7);
    apb(1'b1, OFF_ADDR, 32'hf0);
    i_link.start();
    i_link.xfer(8'hf0, r, ack);
    chk("high addr ack", {31'h0, ack}, 32'h0);
    rdc("reload set", OFF_STAT, 32'h02, 32'h02);
    apb(1'b1, OFF_ADDR, 32'h33);
    rdc("reload clear", OFF_STAT, 32'h02, 32'h0);
    i_link.stop();
  endtask
  task automatic t_spi();
    // leave i2c through disable so the stop flag does not linger
    apb(1'b1, OFF_CTRL, 32'h0);
    rdc("stop cleared", OFF_STAT, 32'h18, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_BUF, 32'h3c);
    i_link.spi(8'h96, r);
    chk("spi out", {24'h0, r}, 32'h3c);
    rdc("spi full", OFF_STAT, 32'h19, 32'h01);
    rdc("spi in", OFF_BUF, 32'hff, 32'h96);
    rdc("spi empty", OFF_STAT, 32'h01, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_i2c_write();
    t_i2c_read();
    t_ten_bit();
    t_spi();
    report_and_stop();
  end
endmodule // sync_serial_port_status_tb
`default_nettype wire

// ### rtl/ssps_sync.sv
// two-flop synchroniser for the link pins
`default_nettype none
module ssps_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] din,
  output logic [2:0] dout
);
  import ssps_pkg::*;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } ssps_sync_s;
  ssps_sync_s q;
  ssps_sync_s d;

  // first stage feeds only the second stage
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // pins idle high, so no false edge follows reset
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule // ssps_sync
`default_nettype wire

// ### rtl/ssps_top.sv
// status flag logic of the sync serial port with APB registers
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module ssps_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ss_n_i,
  output logic sda_o,
  output logic sda_oe,
  output logic sdo,
  output logic sdo_oe,
  output logic irq
);
  import ssps_pkg::*;

  typedef struct packed {
    ssps_link_e st;
    ssps_link_e nxt;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] buf_v;
    logic [7:0] addr;
    logic [2:0] ctrl;
    logic da;
    logic p;
    logic s;
    logic rw;
    logic reload;
    logic full;
    logic hi_ok;
    logic lo_next;
    logic [2:0] irq_st;
    logic [2:0] mask;
    logic scl_p;
    logic sda_p;
    logic sda_o;
    logic sda_oe;
    logic sdo;
    logic sdo_oe;
    logic irqo;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssps_state_s;

  ssps_state_s q;
  ssps_state_s d;
  logic [2:0] pins;
  logic scl;
  logic sda;
  logic ssn;
  logic rise;
  logic fall;
  logic en;
  logic i2c;
  logic ten;
  logic setup;
  logic acc;
  logic hit;
  logic ev_start;
  logic ev_stop;
  logic ev_match;
  logic ev_rx;
  logic ev_tx;
  logic [7:0] byte_in;
  logic [5:0] stat;

  ////////////////////////////////////////////////////////////////////
  // pins cross into pclk before any use
  ssps_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({ss_n_i, sda_i, scl_i}),
    .dout(pins)
  );

  assign scl = pins[0];
  assign sda = pins[1];
  assign ssn = pins[2];
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign en = q.ctrl[CT_EN];
  assign i2c = q.ctrl[CT_I2C];
  assign ten = q.ctrl[CT_TEN];
  assign setup = psel & ~penable & ~q.pready;
  assign acc = psel & penable & q.pready;
  assign byte_in = {q.sr[6:0], sda};
  assign stat = {q.da, q.p, q.s, q.rw, q.reload, q.full};
  assign hit = (paddr == OFF_CTRL) | (paddr == OFF_STAT) |
               (paddr == OFF_BUF) | (paddr == OFF_ADDR) |
               (paddr == OFF_IRQ) | (paddr == OFF_MASK);

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    ev_start = 1'b0;
    ev_stop = 1'b0;
    ev_match = 1'b0;
    ev_rx = 1'b0;
    ev_tx = 1'b0;
    d.scl_p = scl;
    d.sda_p = sda;
    d.sda_o = 1'b0;
    d.pready = setup;
    // bus slave: answer one cycle after setup, snapshot read data
    if (setup) begin
      d.pslverr = ~hit;
      d.prdata = '0;
      case (paddr)
        OFF_CTRL: d.prdata[2:0] = q.ctrl;
        OFF_STAT: d.prdata[5:0] = stat;
        OFF_BUF: d.prdata[7:0] = q.buf_v;
        OFF_ADDR: d.prdata[7:0] = q.addr;
        OFF_IRQ: d.prdata[2:0] = q.irq_st;
        OFF_MASK: d.prdata[2:0] = q.mask;
        default: d.prdata = '0;
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        OFF_CTRL: d.ctrl = pwdata[2:0];
        OFF_BUF: begin
          d.buf_v = pwdata[7:0];
          if (i2c) begin
            d.full = 1'b1;
          end else if (q.cnt == 4'h0) begin
            d.sr = pwdata[7:0];
          end
        end
        OFF_ADDR: begin
          d.addr = pwdata[7:0];
          d.reload = 1'b0;
        end
        OFF_MASK: d.mask = pwdata[2:0];
        default: d.mask = q.mask;
      endcase
    end
    if (acc && !pwrite) begin
      // only bits shown to software are cleared, so none is lost
      if (paddr == OFF_IRQ) begin
        d.irq_st = q.irq_st & ~q.prdata[2:0];
      end
      if (paddr == OFF_BUF && !(i2c && q.st == LK_TX)) begin
        d.full = 1'b0;
      end
    end
    ////////////////////////////////////////////////////////////////
    // protocol select
    if (en && i2c) begin
      d.sdo_oe = 1'b0;
      if (scl && q.scl_p && !sda && q.sda_p) begin
        ev_start = 1'b1;
        d.s = 1'b1;
        d.p = 1'b0;
        d.rw = 1'b0;
        d.st = LK_ADDR;
        d.cnt = 4'h0;
        d.sda_oe = 1'b0;
      end else if (scl && q.scl_p && sda && !q.sda_p) begin
        ev_stop = 1'b1;
        d.p = 1'b1;
        d.s = 1'b0;
        d.rw = 1'b0;
        d.st = LK_IDLE;
        d.sda_oe = 1'b0;
        d.hi_ok = 1'b0;
        d.lo_next = 1'b0;
      end else begin
        case (q.st)
          LK_ADDR, LK_RX: begin
            if (rise) begin
              d.sr = byte_in;
              d.cnt = q.cnt + 4'h1;
              if (q.cnt == BIT_LAST) begin
                d.cnt = 4'h0;
                d.st = LK_ACK;
                if (q.st == LK_RX) begin
                  ev_rx = 1'b1;
                  d.buf_v = byte_in;
                  d.full = 1'b1;
                  d.da = 1'b1;
                  d.nxt = LK_RX;
                end else if (q.lo_next) begin
                  if (byte_in == q.addr) begin
                    ev_match = 1'b1;
                    d.hi_ok = 1'b1;
                    d.lo_next = 1'b0;
                    d.nxt = LK_RX;
                  end else begin
                    d.st = LK_IDLE;
                  end
                end else if (byte_in[7:1] == q.addr[7:1] &&
                             (!ten || !byte_in[0] || q.hi_ok)) begin
                  ev_match = 1'b1;
                  d.rw = byte_in[0];
                  d.lo_next = ten & ~byte_in[0];
                  if (byte_in[0]) begin
                    d.nxt = LK_TX;
                  end else if (ten) begin
                    d.nxt = LK_ADDR;
                  end else begin
                    d.nxt = LK_RX;
                  end
                end else begin
                  d.st = LK_IDLE;
                end
                if (d.st == LK_ACK && ev_match) begin
                  d.da = 1'b0;
                  d.reload = ten;
                end
              end
            end
          end
          LK_ACK: begin
            if (fall) begin
              if (!q.sda_oe) begin
                d.sda_oe = 1'b1;
              end else begin
                d.sda_oe = 1'b0;
                d.st = q.nxt;
                d.cnt = 4'h0;
                if (q.nxt == LK_TX) begin
                  d.sr = q.buf_v;
                  d.sda_oe = ~q.buf_v[7];
                end
              end
            end
          end
          LK_TX: begin
            if (rise) begin
              d.sr = {q.sr[6:0], 1'b0};
              d.cnt = q.cnt + 4'h1;
              if (q.cnt == BIT_LAST) begin
                ev_tx = 1'b1;
                d.full = 1'b0;
                d.da = 1'b1;
                d.cnt = 4'h0;
                d.st = LK_TXACK;
              end
            end else if (fall) begin
              d.sda_oe = ~q.sr[7];
            end
          end
          LK_TXACK: begin
            if (fall) begin
              d.sda_oe = 1'b0;
            end else if (rise) begin
              // a not-ack from the master ends the read
              if (sda) begin
                d.st = LK_IDLE;
                d.rw = 1'b0;
              end else begin
                d.st = LK_TX;
                d.sr = q.buf_v;
              end
            end
          end
          default: d.st = LK_IDLE;
        endcase
      end
    end else if (en) begin
      // spi slave: sample on rising, shift out on falling
      d.sdo_oe = ~ssn;
      d.sda_oe = 1'b0;
      if (ssn) begin
        d.cnt = 4'h0;
        d.sdo = q.sr[7];
      end else if (rise) begin
        d.sr = byte_in;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == BIT_LAST) begin
          ev_rx = 1'b1;
          d.cnt = 4'h0;
          d.buf_v = byte_in;
          d.full = 1'b1;
          d.da = 1'b1;
        end
      end else if (fall) begin
        d.sdo = q.sr[7];
      end
    end else begin
      d.s = 1'b0;
      d.p = 1'b0;
      d.st = LK_IDLE;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
      d.sdo_oe = 1'b0;
      d.hi_ok = 1'b0;
      d.lo_next = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // events win over a read clear in the same cycle
    d.irq_st[IR_BYTE] = d.irq_st[IR_BYTE] | ev_rx | ev_tx;
    d.irq_st[IR_START] = d.irq_st[IR_START] | ev_start;
    d.irq_st[IR_STOP] = d.irq_st[IR_STOP] | ev_stop;
    d.irqo = |(d.irq_st & d.mask);
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= LK_IDLE;
      q.nxt <= LK_IDLE;
      q.ctrl <= RST_CTRL;
      q.addr <= RST_ADDR;
      q.buf_v <= RST_BUF;
      q.mask <= RST_MASK;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sda_o = q.sda_o;
  assign sda_oe = q.sda_oe;
  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;
  assign irq = q.irqo;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_status_top_zero: assert property (
    setup && paddr == OFF_STAT |=> prdata[31:6] == '0
  ) else $error("status upper bits not zero");

  chk_status_read: assert property (
    setup && paddr == OFF_STAT |=> prdata[5:0] == $past(stat)
  ) else $error("status read mismatch");

  chk_start_flag: assert property (
    ev_start |=> q.s && !q.p
  ) else $error("start not flagged");

  chk_stop_flag: assert property (
    ev_stop |=> q.p && !q.s
  ) else $error("stop not flagged");

  chk_disable_clear: assert property (
    !en |=> !q.s && !q.p
  ) else $error("start or stop held while disabled");

  chk_spi_no_cond: assert property (
    en && !i2c && !q.s && !q.p |=> !q.s && !q.p
  ) else $error("bus condition flagged in spi mode");

  chk_rx_full: assert property (
    ev_rx |=> q.full && q.da ##1 q.irq_st[IR_BYTE]
  ) else $error("receive did not fill buffer");

  chk_addr_capture: assert property (
    ev_match && !q.lo_next |=> !q.da && q.rw == $past(sda)
  ) else $error("address match capture wrong");

  chk_addr_reload: assert property (
    ev_match |=> q.reload == ten
  ) else $error("address reload flag wrong");

  chk_tx_done: assert property (
    ev_tx |=> !q.full && q.st == LK_TXACK
  ) else $error("transmit done left buffer full");

  chk_irq_out: assert property (
    $rose(q.irq_st[IR_START]) && q.mask[IR_START] |-> irq
  ) else $error("unmasked event did not raise irq");

  cv_i2c_match: cover property (ev_match ##[1:400] ev_rx);
  cv_i2c_read: cover property (ev_tx ##[1:400] ev_stop);
  cv_spi_byte: cover property (en && !i2c && ev_rx);
  cv_irq_clear: cover property (irq ##1 !irq);
endmodule // ssps_top
`default_nettype wire

// ### shared/ssps_pkg.sv
// constants and types of the sync serial port status block
// Function
// - two protocols: SPI or I2C, by config
// - status bits 7 and 6 read zero
// - data/address bit: 1 data, 0 address
// - I2C stop bit set when stop last
// - I2C start bit set when start last
// - disabling port clears start and stop bits
// - buffer full set when reception completes
// - status at 94h, read-only, resets zero
`default_nettype none
package ssps_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h90;
  localparam logic [7:0] OFF_STAT = 8'h94;
  localparam logic [7:0] OFF_BUF = 8'h98;
  localparam logic [7:0] OFF_ADDR = 8'h9c;
  localparam logic [7:0] OFF_IRQ = 8'ha0;
  localparam logic [7:0] OFF_MASK = 8'ha4;
  // control fields
  localparam int CT_EN = 0;
  localparam int CT_I2C = 1;
  localparam int CT_TEN = 2;
  // status fields
  localparam int ST_DA = 5;
  localparam int ST_P = 4;
  localparam int ST_S = 3;
  localparam int ST_RW = 2;
  localparam int ST_RELOAD = 1;
  localparam int ST_FULL = 0;
  // interrupt fields
  localparam int IR_BYTE = 0;
  localparam int IR_START = 1;
  localparam int IR_STOP = 2;
  // reset values
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic [2:0] RST_MASK = 3'h0;
  // last bit index of a byte
  localparam logic [3:0] BIT_LAST = 4'h7;
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_RX, LK_ACK, LK_TX, LK_TXACK
  } ssps_link_e;
endpackage
`default_nettype wire
